// *** design/lccc_cell.sv ***
// One logic cell: lookup table, cascade/carry stage and configurable flip-flop
`timescale 1ns/1ps
`default_nettype none
module lccc_cell import lccc_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Configuration
   input wire lccc_cell_cfg_type cfg,
   input wire lccc_cell_ctl_type ctl,
   // Control sources and data
   input wire logic [N_SRC-1:0] srcVec,
   input wire logic [3:0] data,
   input wire logic carryIn,
   input wire logic cascadeIn,
   // Results
   output lccc_cell_out_type cout
);

   typedef struct packed {
      logic ffQ;
      logic clkPrev;
   } lccc_cell_state_type;

   lccc_cell_state_type s_r;
   lccc_cell_state_type s_nxt;
   logic [3:0] lutIdx;
   logic [2:0] arIdx;
   logic lutRes;
   logic carryRes;
   logic comb;
   logic clkEdge;
   logic clrN;
   logic preN;

   ////////////////////////////////////////////////////////////////////////
   // Table lookup and chain stages
   always_comb begin
      lutIdx = {(cfg.carrySel ? carryIn : data[3]), data[2:0]};
      arIdx = {carryIn, data[1:0]};
      if (cfg.arith) begin
         lutRes = cfg.lut[{1'b0, arIdx}];
         carryRes = cfg.lut[{1'b1, arIdx}];
      end else begin
         lutRes = cfg.lut[lutIdx];
         carryRes = carryIn;
      end
      // OR form is AND of inverted terms, inverted back
      if (!cfg.casUse) begin
         comb = lutRes;
      end else if (cfg.casOr) begin
         comb = ~(~lutRes & ~cascadeIn);
      end else begin
         comb = lutRes & cascadeIn;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flip-flop controls; clock taken as rising edge of the chosen source
   assign clkEdge = srcVec[ctl.clkSel] & ~s_r.clkPrev;
   assign clrN = srcVec[ctl.clrSel];
   assign preN = srcVec[ctl.preSel];

   // Clear wins over preset; both are sampled, so a glitch is ignored
   always_comb begin
      s_nxt = s_r;
      s_nxt.clkPrev = srcVec[ctl.clkSel];
      if (!clrN) begin
         s_nxt.ffQ = 1'b0;
      end else if (!preN) begin
         s_nxt.ffQ = 1'b1;
      end else if (clkEdge) begin
         case (cfg.ffType)
            FF_D: s_nxt.ffQ = comb;
            FF_T: s_nxt.ffQ = s_r.ffQ ^ comb;
            FF_JK: begin
               case ({comb, data[3]})
                  2'b10: s_nxt.ffQ = 1'b1;
                  2'b01: s_nxt.ffQ = 1'b0;
                  2'b11: s_nxt.ffQ = ~s_r.ffQ;
                  default: s_nxt.ffQ = s_r.ffQ;
               endcase
            end
            FF_SR: begin
               if (comb) begin
                  s_nxt.ffQ = 1'b1;
               end else if (data[3]) begin
                  s_nxt.ffQ = 1'b0;
               end
            end
            default: s_nxt.ffQ = s_r.ffQ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         // Previous clock level starts at the idle level of the reset-time
         // source (constant high), so no false edge follows reset
         s_r.ffQ <= 1'b0;
         s_r.clkPrev <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two independently selected outputs, bypass when unregistered
   assign cout.localOut = cfg.localSel ? s_r.ffQ : comb;
   assign cout.rowOut = cfg.rowSel ? s_r.ffQ : comb;
   assign cout.carryOut = carryRes;
   assign cout.cascadeOut = comb;
   assign cout.ffQ = s_r.ffQ;

endmodule
`default_nettype wire

// *** design/lccc_pkg.sv ***
// Constants, field layouts and carrier types for the logic cell row
package lccc_pkg;

   // Row geometry: the RAM block splits the row into two halves
   localparam int CELLS_PER_CLUSTER = 8;
   localparam int N_CLUSTERS = 8;
   localparam int CLUSTERS_PER_HALF = 4;
   localparam int CLUSTER_HOP = 2;
   localparam int N_CELLS = 64;
   localparam int N_GLOBALS = 4;
   localparam int N_DEDICATED = 6;
   localparam int N_PINS = 8;
   localparam int N_SRC = 16;
   localparam int CELL_IDX_W = 6;

   // Control source vector layout
   localparam logic [3:0] SRC_GLOBAL0 = 4'h0;
   localparam int SRC_DED_LSB = 4;
   localparam int SRC_PIN_LSB = 6;
   localparam int SRC_INTERNAL = 14;
   localparam logic [3:0] SRC_HIGH = 4'hF;

   // Register map, byte addresses on a 10-bit window
   localparam int ADDR_W = 10;
   localparam logic [1:0] REGION_CFG = 2'h0;
   localparam logic [1:0] REGION_CTL = 2'h1;
   localparam logic [1:0] REGION_MISC = 2'h2;
   localparam logic [5:0] MISC_GLOBAL = 6'h00;
   localparam logic [5:0] MISC_CHAIN = 6'h01;
   localparam logic [5:0] MISC_INTSEL = 6'h02;
   localparam logic [5:0] MISC_LOCAL_LO = 6'h03;
   localparam logic [5:0] MISC_LOCAL_HI = 6'h04;
   localparam logic [5:0] MISC_ROW_LO = 6'h05;
   localparam logic [5:0] MISC_ROW_HI = 6'h06;
   localparam logic [5:0] MISC_FFQ_LO = 6'h07;
   localparam logic [5:0] MISC_FFQ_HI = 6'h08;

   // Field positions inside the misc registers
   localparam int CHAIN_START_LSB = 0;
   localparam int CHAIN_LINK_LSB = 8;
   localparam int GSEL_INT_LSB = 0;
   localparam int GSEL_IDX_LSB = 8;
   localparam int GSEL_IDX_W = 6;

   // Reset values
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CTL_RESET = 32'h0000_0FFF;
   localparam logic [31:0] MISC_RESET = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      FF_D = 2'b00,
      FF_T = 2'b01,
      FF_JK = 2'b10,
      FF_SR = 2'b11
   } lccc_ff_type;

   typedef struct packed {
      logic [7:0] rsvd;
      logic rowSel;     // Row output: 1 = flip-flop, 0 = combinational
      logic localSel;   // Local output: 1 = flip-flop, 0 = combinational
      logic carrySel;   // Normal mode: table input 3 from carry-in
      logic casOr;      // Cascade combines by OR instead of AND
      logic casUse;     // Combine table result with cascade-in
      logic arith;      // Arithmetic mode: two 3-input tables
      lccc_ff_type ffType;
      logic [15:0] lut;
   } lccc_cell_cfg_type;

   typedef struct packed {
      logic [19:0] rsvd;
      logic [3:0] clkSel;
      logic [3:0] clrSel;
      logic [3:0] preSel;
   } lccc_cell_ctl_type;

   typedef struct packed {
      logic localOut;
      logic rowOut;
      logic carryOut;
      logic cascadeOut;
      logic ffQ;
   } lccc_cell_out_type;

endpackage

// *** design/lccc_row.sv ***
// Row of logic cell clusters with carry/cascade chains and AXI4-Lite config
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lccc_row import lccc_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // AXI4-Lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Dedicated inputs and general-purpose pins
   input wire logic [N_DEDICATED-1:0] dedIn,
   input wire logic [N_PINS-1:0] gpPin,
   // Cell routing
   input wire logic [N_CELLS-1:0][3:0] cellData,
   output logic [N_CELLS-1:0] localOut,
   output logic [N_CELLS-1:0] rowOut,
   output logic [N_GLOBALS-1:0] globalSig
);

   typedef struct packed {
      logic [N_CELLS-1:0][31:0] cfgWord;
      logic [N_CELLS-1:0][31:0] ctlWord;
      logic [31:0] gsel;
      logic [31:0] chain;
      logic [CELL_IDX_W-1:0] intSel;
      logic awPend;
      logic [ADDR_W-1:0] awAddr;
      logic wPend;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } lccc_row_state_type;

   lccc_row_state_type s_r;
   lccc_row_state_type s_nxt;
   lccc_cell_out_type [N_CELLS-1:0] cout;
   logic [N_CELLS-1:0] carryIn;
   logic [N_CELLS-1:0] cascadeIn;
   logic [N_CELLS-1:0] ffQ;
   logic [N_SRC-1:0] srcVec;
   logic [31:0] rdWord;
   logic rdOk;

   // Byte-lane merge for partial writes
   function automatic logic [31:0] lccc_merge(input logic [31:0] oldW,
                                              input logic [31:0] newW,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = oldW;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = newW[8*b +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Global signals: dedicated input or any cell's local output
   always_comb begin
      for (int g = 0; g < N_GLOBALS; g++) begin
         if (s_r.gsel[GSEL_INT_LSB + g]) begin
            globalSig[g] = localOut[s_r.gsel[GSEL_IDX_LSB + g*GSEL_IDX_W
                                              +: GSEL_IDX_W]];
         end else begin
            globalSig[g] = dedIn[g];
         end
      end
   end

   // Control sources; the top entry is constant high for unused controls
   assign srcVec = {1'b1,
                    localOut[s_r.intSel],
                    gpPin,
                    dedIn[N_DEDICATED-1:N_GLOBALS],
                    globalSig};

   ////////////////////////////////////////////////////////////////////////
   // Cells and chain wiring; the hop skips one cluster to keep parity and
   // never crosses from one half of the row into the other
   for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
      localparam int C = i / CELLS_PER_CLUSTER;
      localparam int P = i % CELLS_PER_CLUSTER;
      localparam int SRC_CELL = i - CLUSTER_HOP*CELLS_PER_CLUSTER
                                + CELLS_PER_CLUSTER - 1;
      lccc_cell_cfg_type cfgI;
      assign cfgI = lccc_cell_cfg_type'(s_r.cfgWord[i]);

      if (P != 0) begin : g_inner
         assign carryIn[i] = cout[i-1].carryOut;
         assign cascadeIn[i] = cout[i-1].cascadeOut;
      end else if ((C % CLUSTERS_PER_HALF) >= CLUSTER_HOP) begin : g_hop
         // Link enabled: continue from same-parity cluster two back
         assign carryIn[i] = s_r.chain[CHAIN_LINK_LSB + C]
                             ? cout[SRC_CELL].carryOut
                             : s_r.chain[CHAIN_START_LSB + C];
         assign cascadeIn[i] = s_r.chain[CHAIN_LINK_LSB + C]
                               ? cout[SRC_CELL].cascadeOut
                               : ~cfgI.casOr;
      end else begin : g_start
         // First clusters of each half start a fresh chain at the RAM
         assign carryIn[i] = s_r.chain[CHAIN_START_LSB + C];
         assign cascadeIn[i] = ~cfgI.casOr;
      end

      lccc_cell u_cell (
         .core_clk (core_clk),
         .rst_b (rst_b),
         .cfg (cfgI),
         .ctl (lccc_cell_ctl_type'(s_r.ctlWord[i])),
         .srcVec (srcVec),
         .data (cellData[i]),
         .carryIn (carryIn[i]),
         .cascadeIn (cascadeIn[i]),
         .cout (cout[i])
      );

      assign localOut[i] = cout[i].localOut;
      assign rowOut[i] = cout[i].rowOut;
      assign ffQ[i] = cout[i].ffQ;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode; unmapped addresses answer zero with SLVERR
   always_comb begin
      rdWord = 32'h0000_0000;
      rdOk = 1'b1;
      case (s_axi_araddr[ADDR_W-1:ADDR_W-2])
         REGION_CFG: rdWord = s_r.cfgWord[s_axi_araddr[7:2]];
         REGION_CTL: rdWord = s_r.ctlWord[s_axi_araddr[7:2]];
         REGION_MISC: begin
            case (s_axi_araddr[7:2])
               MISC_GLOBAL: rdWord = s_r.gsel;
               MISC_CHAIN: rdWord = s_r.chain;
               MISC_INTSEL: rdWord = {26'h0, s_r.intSel};
               MISC_LOCAL_LO: rdWord = localOut[31:0];
               MISC_LOCAL_HI: rdWord = localOut[63:32];
               MISC_ROW_LO: rdWord = rowOut[31:0];
               MISC_ROW_HI: rdWord = rowOut[63:32];
               MISC_FFQ_LO: rdWord = ffQ[31:0];
               MISC_FFQ_HI: rdWord = ffQ[63:32];
               default: rdOk = 1'b0;
            endcase
         end
         default: rdOk = 1'b0;
      endcase
   end

   // One write and one read in flight; address and data taken in any order
   assign s_axi_awready = ~s_r.awPend & ~s_r.bvalid;
   assign s_axi_wready = ~s_r.wPend & ~s_r.bvalid;
   assign s_axi_arready = ~s_r.rvalid;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave next state and register writes
   always_comb begin
      s_nxt = s_r;
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.awPend = 1'b1;
         s_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.wPend = 1'b1;
         s_nxt.wData = s_axi_wdata;
         s_nxt.wStrb = s_axi_wstrb;
      end
      // Commit once both halves are held; response on the next edge
      if (s_r.awPend && s_r.wPend && !s_r.bvalid) begin
         s_nxt.awPend = 1'b0;
         s_nxt.wPend = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         case (s_r.awAddr[ADDR_W-1:ADDR_W-2])
            REGION_CFG: s_nxt.cfgWord[s_r.awAddr[7:2]] =
               lccc_merge(s_r.cfgWord[s_r.awAddr[7:2]], s_r.wData, s_r.wStrb);
            REGION_CTL: s_nxt.ctlWord[s_r.awAddr[7:2]] =
               lccc_merge(s_r.ctlWord[s_r.awAddr[7:2]], s_r.wData, s_r.wStrb);
            REGION_MISC: begin
               case (s_r.awAddr[7:2])
                  MISC_GLOBAL: s_nxt.gsel =
                     lccc_merge(s_r.gsel, s_r.wData, s_r.wStrb);
                  MISC_CHAIN: s_nxt.chain =
                     lccc_merge(s_r.chain, s_r.wData, s_r.wStrb);
                  MISC_INTSEL: begin
                     if (s_r.wStrb[0]) begin
                        s_nxt.intSel = s_r.wData[CELL_IDX_W-1:0];
                     end
                  end
                  // Status words are read only; writes are accepted and dropped
                  MISC_LOCAL_LO, MISC_LOCAL_HI, MISC_ROW_LO, MISC_ROW_HI,
                  MISC_FFQ_LO, MISC_FFQ_HI: s_nxt.bresp = RESP_OKAY;
                  default: s_nxt.bresp = RESP_SLVERR;
               endcase
            end
            default: s_nxt.bresp = RESP_SLVERR;
         endcase
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rdWord;
         s_nxt.rresp = rdOk ? RESP_OKAY : RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; control selectors reset to constant high so no cell
   // sees a clock edge, clear or preset until software programs it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
         for (int k = 0; k < N_CELLS; k++) begin
            s_r.cfgWord[k] <= CFG_RESET;
            s_r.ctlWord[k] <= CTL_RESET;
         end
         s_r.gsel <= MISC_RESET;
         s_r.chain <= MISC_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;

endmodule
`default_nettype wire

// *** dv/lccc_nbr_model.sv ***
// Neighbour logic driving the row's pins: clock bursts and static levels
`timescale 1ns/1ps
`default_nettype none
module lccc_nbr_model import lccc_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Requests from the bench
   input wire logic trig,
   input wire logic [3:0] nPulse,
   input wire logic [N_PINS-2:0] pinHi,
   // Pins seen by the row
   output logic [N_PINS-1:0] gpPin
);
   logic [5:0] ph_r;
   // Two cycles high, two low per pulse; still between bursts
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) ph_r <= '0;
      else if (trig) ph_r <= {nPulse, 2'h0};
      else if (ph_r != '0) ph_r <= ph_r - 6'h01;
   end
   assign gpPin = {pinHi, ph_r[1]};
endmodule
`default_nettype wire

// *** dv/lccc_row_assertions.sv ***
// Checker of the row's bus handshakes and reset-state outputs
`timescale 1ns/1ps
`default_nettype none
module lccc_row_assertions import lccc_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Register bus
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins and cell outputs
   input wire logic [N_DEDICATED-1:0] dedIn,
   input wire logic [N_CELLS-1:0] localOut,
   input wire logic [N_CELLS-1:0] rowOut,
   input wire logic [N_GLOBALS-1:0] globalSig
);
   logic anyWr_r;
   logic gOvr_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // Track writes; outputs may only move once configuration was touched
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         anyWr_r <= 1'b0;
         gOvr_r <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         anyWr_r <= 1'b1;
         gOvr_r <= gOvr_r || s_axi_awaddr == 10'h200;
      end
   end
   // Handshake steps
   sequence s_wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_idleOut;
      !anyWr_r |-> localOut == '0 && rowOut == '0;
   endproperty
   property p_globalDed;
      !gOvr_r |-> globalSig == dedIn[N_GLOBALS-1:0];
   endproperty
   property p_wrResp;
      s_wrTaken |-> ##2 s_axi_bvalid;
   endproperty
   property p_bHold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_bBusy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_rdResp;
      s_rdTaken |=> s_axi_rvalid;
   endproperty
   property p_rHold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rDone;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   property p_unmapRd;
      s_rdTaken ##0 (s_axi_araddr[9:8] == REGION_MISC &&
         s_axi_araddr[7:2] > 6'h08) |=>
         s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
   endproperty
   a_idleOut: assert property (p_idleOut)
      else $error("cell output high before any configuration");
   a_globalDed: assert property (p_globalDed)
      else $error("global line differs from dedicated input");
   a_wrResp: assert property (p_wrResp)
      else $error("write response late");
   a_bHold: assert property (p_bHold)
      else $error("write response dropped or changed");
   a_bBusy: assert property (p_bBusy)
      else $error("write accepted while response pending");
   a_rdResp: assert property (p_rdResp)
      else $error("read data late");
   a_rHold: assert property (p_rHold)
      else $error("read data dropped or changed");
   a_rDone: assert property (p_rDone)
      else $error("read data held after handshake");
   a_unmapRd: assert property (p_unmapRd)
      else $error("unmapped read not refused");
endmodule
bind lccc_row lccc_row_assertions lccc_row_assertions_inst (.*);
`default_nettype wire

// *** dv/lccc_row_tb.sv ***
// Self-checking bench for the logic cell row
`timescale 1ns/1ps
`default_nettype none
module lccc_row_tb import lccc_pkg::*;;
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0] r;
   } lccc_note_type;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0;
   logic [ADDR_W-1:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [N_DEDICATED-1:0] dedIn = '0;
   logic [N_PINS-1:0] gpPin;
   logic [N_CELLS-1:0][3:0] cellData = '0;
   logic [N_CELLS-1:0] localOut, rowOut;
   logic [N_GLOBALS-1:0] globalSig;
   logic trig = 1'b0;
   logic [3:0] nPulse = '0;
   logic [N_PINS-2:0] pinHi = '1;
   logic stall = 1'b0;
   logic [31:0] rng = 32'hB793;
   logic [10:0] sum;
   logic [9:0] opA, opB;
   logic [3:0] ffExp = 4'h9;
   lccc_note_type notes[$];
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   lccc_row lccc_row_inst (.*);
   lccc_nbr_model lccc_nbr_model_inst (.*);
   ////////////////////////////////////////
   // 100 MHz clock
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Write; a stalled master raises bready only once bvalid is seen
   task automatic wr(input logic [9:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      notes.push_back('{d, 32'h0, r});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !stall;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask
   // Read with expected data under a mask
   task automatic rd(input logic [9:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [1:0] r);
      notes.push_back('{d, m, r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !stall;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask
   // Burst of n rising edges on the neighbour clock pin
   task automatic pulse(input logic [3:0] n);
      trig <= 1'b1;
      nPulse <= n;
      @(posedge core_clk);
      trig <= 1'b0;
      repeat (4 * n + 4) @(posedge core_clk);
   endtask
   // Pair each bus answer with the oldest expectation
   always @(posedge core_clk) begin
      if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
         chk(s_axi_rdata & notes[0].m, notes[0].d & notes[0].m);
         chk({30'h0, s_axi_rvalid ? s_axi_rresp : s_axi_bresp},
             {30'h0, notes[0].r});
         void'(notes.pop_front());
      end
   end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end
   ////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < N_CELLS; i++) begin
         cellData[i] <= rng[3:0];
         rng = xs(rng);
      end
      dedIn <= rng[N_DEDICATED-1:0];
      @(posedge core_clk);
      chk({28'h0, globalSig}, {28'h0, dedIn[3:0]});
      rd(10'h100, 32'h0000_0FFF, 32'hFFFF_FFFF, RESP_OKAY);
      rd(10'h000, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
      stall = 1'b1;
      rd(10'h240, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(10'h240, 32'h1, RESP_SLVERR);
      stall = 1'b0;
      // Cascade AND over cells 8..11, identity fed at the chain head
      for (int i = 8; i < 12; i++) wr(10'(4 * i), 32'h0008_8000, RESP_OKAY);
      for (int i = 8; i < 12; i++) cellData[i] <= 4'hF;
      rd(10'h20C, 32'h800, 32'h800, RESP_OKAY);
      cellData[8 + rng[1:0]][rng[3:2]] <= 1'b0;
      rd(10'h20C, 32'h0, 32'h800, RESP_OKAY);
      // Cascade OR form
      for (int i = 8; i < 12; i++) wr(10'(4 * i), 32'h0019_FFFE, RESP_OKAY);
      for (int i = 8; i < 12; i++) cellData[i] <= 4'h0;
      rd(10'h20C, 32'h0, 32'h800, RESP_OKAY);
      cellData[8 + rng[5:4]][rng[7:6]] <= 1'b1;
      dedIn[0] <= 1'b0;
      rd(10'h20C, 32'h800, 32'h800, RESP_OKAY);
      // Global 0 taken over by cell 11
      wr(10'h200, 32'h0000_0B01, RESP_OKAY);
      chk({28'h0, globalSig}, {28'h0, dedIn[3:1], 1'b1});
      // Ten-bit adder: cluster 0 then hop to cluster 2
      for (int i = 0; i < 18; i++)
         if (i < 8 || i > 15) wr(10'(4 * i), 32'h0004_E896, RESP_OKAY);
      wr(10'h080, 32'h0004_E896, RESP_OKAY);
      cellData[32] <= 4'h0;
      for (int t = 0; t < 2; t++) begin
         opA = rng[9:0];
         opB = rng[25:16];
         rng = xs(rng);
         sum = {1'b0, opA} + {1'b0, opB} + 11'(t);
         for (int k = 0; k < 10; k++)
            cellData[k < 8 ? k : k + 8] <= {2'b00, opB[k], opA[k]};
         wr(10'h204, 32'h0000_0410 + 32'(t), RESP_OKAY);
         rd(10'h20C, {14'h0, sum[9:8], 8'h00, sum[7:0]}, 32'h0003_00FF,
            RESP_OKAY);
      end
      rd(10'h210, 32'h1, 32'h1, RESP_OKAY);
      // Flip-flop kinds on cell 40, clocked and cleared from pins
      wr(10'h1A0, 32'h0000_067F, RESP_OKAY);
      for (int t = 0; t < 4; t++) begin
         wr(10'h0A0, {14'h0010, 2'(t), 16'hAAAA}, RESP_OKAY);
         pinHi[0] <= 1'b0;
         repeat (3) @(posedge core_clk);
         pinHi[0] <= 1'b1;
         cellData[40] <= 4'h9;
         pulse(4'h2);
         rd(10'h220, {23'h0, ffExp[t], 8'h00}, 32'h100, RESP_OKAY);
         rd(10'h210, {23'h0, ffExp[t], 8'h00}, 32'h100, RESP_OKAY);
      end
      // Table to row output, register to local output
      cellData[40] <= 4'h8;
      rd(10'h218, 32'h0, 32'h100, RESP_OKAY);
      rd(10'h210, 32'h100, 32'h100, RESP_OKAY);
      // Preset from a pin: one pulse resets the SR cell, then preset low
      wr(10'h1A0, 32'h0000_06F7, RESP_OKAY);
      pulse(4'h1);
      rd(10'h220, 32'h0, 32'h100, RESP_OKAY);
      pinHi[0] <= 1'b0;
      repeat (3) @(posedge core_clk);
      pinHi[0] <= 1'b1;
      rd(10'h220, 32'h100, 32'h100, RESP_OKAY);
      end_sim();
   end
endmodule
`default_nettype wire
